// [bench/fpg_chk.sv]
// fpg_chk: port-level assertions for fpg_top
// assumes one clock domain and a synchronous reset
`timescale 1ns/1ps
module fpg_chk (
  input wire logic             clock_in,
  input wire logic             rst_in,
  input wire fpg_pkg::fpg_sfr_t sfr_in,
  input wire logic [7:0]       sfr_rdata_out,
  input wire logic             xw_in,
  input wire fpg_pkg::fpg_dbg_t dbg_in,
  input wire logic             dbg_busy_out,
  input wire logic             stall_out,
  input wire logic             irq_hold_out,
  input wire logic             reset_req_out,
  input wire logic             xw_to_flash_out
);
  import fpg_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire go = !stall_out && !dbg_busy_out;
  wire psc_rd = sfr_in.rd && sfr_in.addr == FPG_PSC_ADDR;
  rd_zero_a: assert property (psc_rd |=> sfr_rdata_out[7:2] == 6'h00)
    else $error("control upper bits not zero");
  wr_off_a: assert property (xw_in && !xw_to_flash_out && go
    |=> !stall_out && !reset_req_out) else $error("disabled write acted");
  irq_hold_a: assert property (irq_hold_out == stall_out)
    else $error("interrupt hold differs from stall");
  req_once_a: assert property (reset_req_out |=> !reset_req_out)
    else $error("reset request longer than one cycle");
  op_bound_a: assert property (xw_in && xw_to_flash_out && go
    |=> reset_req_out or stall_out ##[1:520] !stall_out)
    else $error("flash operation stall out of bounds");
  dbg_quiet_a: assert property (dbg_in.wr && !xw_in && !sfr_in.wr
    |=> !reset_req_out) else $error("debug access caused reset");
  full_erase_a: assert property (dbg_in.erase_all && go
    |-> ##[1:2] dbg_busy_out) else $error("device erase not started");
  psc_reset_a: assert property (disable iff (1'b0) rst_in
    |=> !xw_to_flash_out && !reset_req_out) else $error("reset value wrong");
  cover property (reset_req_out);
  cover property ($fell(stall_out));
  cover property ($fell(dbg_busy_out));
endmodule
bind fpg_top fpg_chk chk (
  .clock_in        (clock_in),
  .rst_in          (rst_in),
  .sfr_in          (sfr_in),
  .sfr_rdata_out   (sfr_rdata_out),
  .xw_in           (xw_in),
  .dbg_in          (dbg_in),
  .dbg_busy_out    (dbg_busy_out),
  .stall_out       (stall_out),
  .irq_hold_out    (irq_hold_out),
  .reset_req_out   (reset_req_out),
  .xw_to_flash_out (xw_to_flash_out)
);

// [bench/fpg_cpu.sv]
// fpg_cpu: cpu model issuing register accesses, external-move writes and code reads
// assumes requests are taken on a rising edge while stall is low
`timescale 1ns/1ps
module fpg_cpu (
  input  wire logic             clock_in,
  input  wire logic             stall_in,
  input  wire logic [7:0]       rdata_in,
  input  wire logic [7:0]       cdata_in,
  output fpg_pkg::fpg_sfr_t     sfr_out,
  output logic                  xw_out,
  output logic [13:0]           xa_out,
  output logic [7:0]            xd_out,
  output logic                  crd_out,
  output logic [13:0]           ca_out
);
  import fpg_pkg::*;
  initial begin
    sfr_out = '0;
    {xw_out, xa_out, xd_out, crd_out, ca_out} = '0;
  end
  // one idle edge first, so a release and a new request never collide
  task automatic go();
    do begin
      @(posedge clock_in);
      #1;
    end while (stall_in);
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    go();
    sfr_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock_in);
    #1;
    q = rdata_in;
    sfr_out = '{wr: 0, rd: 0, addr: ~a, wdata: ~d};
  endtask
  task automatic xwr(input logic [13:0] a, input logic [7:0] d);
    go();
    {xw_out, xa_out, xd_out} = {1'b1, a, d};
    @(posedge clock_in);
    #1;
    {xw_out, xa_out, xd_out} = {1'b0, ~a, ~d};
  endtask
  task automatic crd(input logic [13:0] a, output logic [7:0] q);
    go();
    {crd_out, ca_out} = {1'b1, a};
    @(posedge clock_in);
    #1;
    crd_out = 0;
    @(posedge clock_in);
    #1;
    q = cdata_in;
    ca_out = ~a;
  endtask
endmodule

// [bench/fpg_tb_top.sv]
// fpg_tb_top: random and corner tests of the flash program guard
// assumes the cpu model on the user side; debug port driven here
`timescale 1ns/1ps
module fpg_tb_top;
  import fpg_pkg::*;
  logic clock_in = 0, rst = 1, xw, crd;
  logic [13:0] pc = 14'h0a00, xa, ca, a;
  logic [7:0] rd, cd, xd, q, d, e, lb = 8'hff;
  logic stall, busy, req, irq, tof;
  fpg_sfr_t sfr;
  fpg_dbg_t dbg = '0;
  int n_mismatch = 0, total_checks = 0, n_req = 0;
  always #50 clock_in = ~clock_in;
  always @(posedge clock_in) if (req === 1'b1) n_req++;
  fpg_cpu cpu (.clock_in(clock_in), .stall_in(stall), .rdata_in(rd),
    .cdata_in(cd), .sfr_out(sfr), .xw_out(xw), .xa_out(xa), .xd_out(xd),
    .crd_out(crd), .ca_out(ca));
  fpg_top DUT (.clock_in(clock_in), .rst_in(rst), .sfr_in(sfr),
    .sfr_rdata_out(rd), .xw_in(xw), .xw_addr_in(xa), .xw_data_in(xd),
    .pc_in(pc), .crd_in(crd), .crd_addr_in(ca), .crd_data_out(cd),
    .dbg_in(dbg), .dbg_busy_out(busy), .stall_out(stall),
    .irq_hold_out(irq), .reset_req_out(req), .xw_to_flash_out(tof));
  task automatic check(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic locked(input logic [7:0] b, input logic [13:0] a);
    return {3'h0, a[13:9]} < ~b || (b != 8'hff && a[13:9] == 5'h1e);
  endfunction
  task automatic reboot(input logic f);
    @(posedge clock_in);
    #1;
    rst = 1;
    repeat (2) @(posedge clock_in);
    #1;
    rst = 0;
    cpu.sfr(0, FPG_RST_ADDR, 8'h00, q);
    if (f) check({7'h00, q[FPG_FERR_BIT]}, 8'h01);
    cpu.sfr(1, FPG_RST_ADDR, 8'(1 << FPG_POR_BIT), q);
    cpu.sfr(0, FPG_RST_ADDR, 8'h00, q);
    check(q, 8'h00);
  endtask
  task automatic op(input logic [7:0] psc, input logic [13:0] a,
                    input logic [7:0] d);
    logic bad;
    bad = psc[0] && locked(lb, a) && !locked(lb, pc);
    n_req = 0;
    cpu.sfr(1, FPG_PSC_ADDR, psc, q);
    cpu.sfr(1, FPG_KEY_ADDR, FPG_KEY1, q);
    cpu.sfr(1, FPG_KEY_ADDR, FPG_KEY2, q);
    cpu.xwr(a, d);
    cpu.sfr(1, FPG_PSC_ADDR, 8'h00, q);
    check(8'(n_req), {7'h00, bad});
    if (bad) reboot(1);
  endtask
  task automatic dbg_op(input logic e, input logic [13:0] a);
    @(posedge clock_in);
    #1;
    dbg = '{wr: !e, erase_all: e, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    #1;
    dbg = '{wr: 0, erase_all: 0, addr: ~a, wdata: 8'hff};
    for (int i = 0; i < 20000 && (busy || stall); i++) begin
      @(posedge clock_in);
      #1;
    end
  endtask
  initial begin
    #6_000_000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hb2e8d3a7));
    repeat (2) @(posedge clock_in);
    #1;
    rst = 0;
    dbg_op(1, 0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      cpu.sfr(1, FPG_PSC_ADDR, d, q);
      cpu.sfr(0, FPG_PSC_ADDR, 8'h00, q);
      check(q, {6'h00, d[1:0]});
      check({7'h00, tof}, {7'h00, d[0]});
    end
    a = 14'h0400 | 14'($urandom % 512);
    d = $urandom;
    e = $urandom;
    op(1, a, d);
    op(1, a, e);
    cpu.crd(a, q);
    check(q, d & e);
    op(3, a ^ 14'h0055, 8'h00);
    cpu.crd(a, q);
    check(q, 8'hff);
    n_req = 0;
    cpu.sfr(1, FPG_PSC_ADDR, 8'h01, q);
    cpu.xwr(a, 8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    check(8'(n_req), 8'h01);
    reboot(1);
    op(0, a, 8'h00);
    cpu.crd(a, q);
    check(q, 8'hff);
    reboot(0);
    op(1, FPG_LOCK_ADDR, 8'hfe);
    op(1, 14'h0010, 8'h3c);
    reboot(0);
    lb = 8'hfe;
    op(1, 14'h0020, 8'h00);
    op(1, 14'h0230, 8'h00);
    op(1, FPG_LOCK_ADDR, 8'h00);
    n_req = 0;
    dbg_op(0, 14'h0030);
    check(8'(n_req), 8'h00);
    pc = 14'h0000;
    cpu.crd(14'h0030, q);
    check(q, 8'hff);
    op(1, 14'h0040, 8'h00);
    dbg_op(1, 0);
    cpu.crd(FPG_LOCK_ADDR, q);
    check(q, 8'hff);
    dbg_op(0, 14'h0030);
    cpu.crd(14'h0030, q);
    check(q, 8'h00);
    finish_test();
  end
endmodule

// [include/fpg_pkg.sv]
// fpg_pkg: constants and carrier types for the flash program/erase guard
// assumes an 8-bit special-function register port and a byte-wide flash
package fpg_pkg;
  localparam int          FPG_AW        = 14;
  localparam int          FPG_PAGE_BITS = 9;
  localparam int          FPG_PAGES     = 32;
  localparam logic [7:0]  FPG_PSC_ADDR  = 8'h8f;
  localparam logic [7:0]  FPG_KEY_ADDR  = 8'hb7;
  localparam logic [7:0]  FPG_RST_ADDR  = 8'hef;
  localparam logic [7:0]  FPG_KEY1      = 8'ha5;
  localparam logic [7:0]  FPG_KEY2      = 8'hf1;
  localparam logic [7:0]  FPG_ERASED    = 8'hff;
  localparam logic [7:0]  FPG_PSC_RST   = 8'h00;
  localparam int          FPG_WE_BIT    = 0;
  localparam int          FPG_EE_BIT    = 1;
  localparam int          FPG_POR_BIT   = 1;
  localparam int          FPG_FERR_BIT  = 6;
  localparam int          FPG_SWR_BIT   = 4;
  localparam logic [13:0] FPG_LOCK_ADDR = 14'h3dff;

  typedef enum logic [1:0] {
    FPG_LOCKED  = 2'b00,
    FPG_KEY_ONE = 2'b01,
    FPG_OPEN    = 2'b10,
    FPG_DEAD    = 2'b11
  } fpg_key_t;

  typedef enum logic [2:0] {
    FPG_IDLE  = 3'b000,
    FPG_ERASE = 3'b001,
    FPG_WRITE = 3'b010,
    FPG_FULL  = 3'b011,
    FPG_BOOT  = 3'b100
  } fpg_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } fpg_sfr_t;

  typedef struct packed {
    logic        wr;
    logic        erase_all;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } fpg_dbg_t;
endpackage

// [src/fpg_mem.sv]
// fpg_mem: byte-wide flash array model with registered read data
// assumes one access per cycle; write port already masked by the guard
`timescale 1ns/1ps
module fpg_mem #(
  parameter int AW = 14
) (
  input  wire logic          clock_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [7:0]    rdata_out
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

// [src/fpg_top.sv]
// fpg_top: flash program/erase guard with key lock and page security
// assumes the cpu stalls on stall_out and resets on reset_req_out
`timescale 1ns/1ps
module fpg_top
  import fpg_pkg::*;
#(
  parameter int AW = FPG_AW
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire fpg_pkg::fpg_sfr_t sfr_in,
  output logic      [7:0]       sfr_rdata_out,
  input  wire logic             xw_in,
  input  wire logic [AW-1:0]    xw_addr_in,
  input  wire logic [7:0]       xw_data_in,
  input  wire logic [AW-1:0]    pc_in,
  input  wire logic             crd_in,
  input  wire logic [AW-1:0]    crd_addr_in,
  output logic      [7:0]       crd_data_out,
  input  wire fpg_pkg::fpg_dbg_t dbg_in,
  output logic                  dbg_busy_out,
  output logic                  stall_out,
  output logic                  irq_hold_out,
  output logic                  reset_req_out,
  output logic                  xw_to_flash_out
);
  import fpg_pkg::*;

  logic [1:0]    psc;
  fpg_key_t      key;
  fpg_state_t    st;
  logic [7:0]    lock_val;
  logic          ferr;
  logic [7:0]    rst_src;
  logic [AW-1:0] ptr;
  logic [7:0]    wbyte;
  logic          user_op;
  logic [7:0]    rdata;
  logic          fault_pend;
  logic          crd_seen;

  // lock value sampled at boot and set erased at the end of a full erase, so a user write waits for reset
  // whole byte compared: a complement past the page count locks them all
  wire [7:0] n_locked = ~lock_val;
  wire any_locked  = lock_val != FPG_ERASED;
  wire [AW-FPG_PAGE_BITS-1:0] lock_page =
    FPG_LOCK_ADDR[AW-1:FPG_PAGE_BITS];
  function automatic logic page_locked(input logic [AW-1:0] a);
    page_locked = (8'(a[AW-1:FPG_PAGE_BITS]) < n_locked) ||
      (any_locked && a[AW-1:FPG_PAGE_BITS] == lock_page);
  endfunction
  wire pc_locked   = page_locked(pc_in);
  wire tgt_locked  = page_locked(xw_addr_in);
  wire tgt_lockpg  = xw_addr_in[AW-1:FPG_PAGE_BITS] == lock_page;
  wire is_erase    = psc[FPG_EE_BIT];
  // lock byte may not be changed once written, nor its page erased
  wire lock_byte_hit = xw_addr_in == FPG_LOCK_ADDR[AW-1:0];
  wire bad_target  = (tgt_locked && !pc_locked) ||
                     (is_erase && tgt_lockpg) ||
                     (lock_byte_hit && lock_val != FPG_ERASED);
  wire flash_wr    = xw_in && psc[FPG_WE_BIT] && st == FPG_IDLE;
  wire key_ok      = key == FPG_OPEN;
  wire user_bad    = flash_wr && (!key_ok || bad_target);
  wire user_go     = flash_wr && key_ok && !bad_target;

  wire dbg_lock    = page_locked(dbg_in.addr) ||
                     dbg_in.addr == FPG_LOCK_ADDR[AW-1:0];
  wire dbg_go      = dbg_in.wr && st == FPG_IDLE && !xw_in &&
                     !dbg_lock;
  wire dbg_full    = dbg_in.erase_all && st == FPG_IDLE && !xw_in;

  wire psc_wr = sfr_in.wr && sfr_in.addr == FPG_PSC_ADDR;
  wire key_wr = sfr_in.wr && sfr_in.addr == FPG_KEY_ADDR;
  wire rst_wr = sfr_in.wr && sfr_in.addr == FPG_RST_ADDR;
  wire [7:0] next_sfr_rdata =
    (sfr_in.addr == FPG_PSC_ADDR) ? {6'h00, psc} :
    (sfr_in.addr == FPG_KEY_ADDR) ? {6'h00, key} :
    (sfr_in.addr == FPG_RST_ADDR) ? rst_src : 8'h00;

  // write clears bits only, erase writes the erased value
  wire          mem_we    = st == FPG_ERASE || st == FPG_FULL ||
                            st == FPG_WRITE;
  wire [7:0]    mem_wdata = (st == FPG_WRITE) ? (wbyte & rdata) :
                            FPG_ERASED;
  // target read on the accepting edge, so the write sees its old byte
  wire [AW-1:0] idle_addr = user_go ? xw_addr_in :
                            dbg_go  ? dbg_in.addr : crd_addr_in;
  // lock byte fetched during reset too, so one reset edge is enough
  wire [AW-1:0] raddr     = (rst_in || st == FPG_BOOT) ?
                            FPG_LOCK_ADDR[AW-1:0] :
                            (st == FPG_IDLE) ? idle_addr : ptr;
  wire          page_end  = &ptr[FPG_PAGE_BITS-1:0];

  fpg_mem #(.AW(AW)) u_mem (
    .clock_in  (clock_in),
    .we_in     (mem_we),
    .waddr_in  (ptr),
    .wdata_in  (mem_wdata),
    .raddr_in  (raddr),
    .rdata_out (rdata)
  );

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      psc <= 2'b00;
      key <= FPG_LOCKED;
    end else begin
      if (psc_wr) psc <= sfr_in.wdata[1:0];
      if (user_bad) key <= FPG_DEAD;
      else if (user_go) key <= FPG_LOCKED;
      else if (key_wr && key != FPG_DEAD) begin
        if (key == FPG_LOCKED && sfr_in.wdata == FPG_KEY1)
          key <= FPG_KEY_ONE;
        else if (key == FPG_KEY_ONE && sfr_in.wdata == FPG_KEY2)
          key <= FPG_OPEN;
        else key <= FPG_DEAD;
      end
    end
  end

  // fault is carried through the reset it caused, so software sees why
  always_ff @(posedge clock_in) begin
    if (user_bad) fault_pend <= 1'b1;
    else if (!rst_in && st == FPG_BOOT) fault_pend <= 1'b0;
    if (rst_in) ferr <= fault_pend;
    else if (rst_wr) ferr <= sfr_in.wdata[FPG_FERR_BIT];
    if (rst_in) rst_src <= 8'h00;
    else rst_src <= {1'b0, ferr, 6'h00};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st       <= FPG_BOOT;
      ptr      <= '0;
      wbyte    <= 8'h00;
      user_op  <= 1'b0;
      lock_val <= FPG_ERASED;
    end else begin
      case (st)
        FPG_BOOT: begin
          lock_val <= rdata;
          st       <= FPG_IDLE;
        end
        FPG_IDLE: begin
          if (dbg_full) begin
            ptr <= '0;
            st  <= FPG_FULL;
          end else if (user_go || dbg_go) begin
            user_op <= user_go;
            if (user_go && is_erase) begin
              ptr <= {xw_addr_in[AW-1:FPG_PAGE_BITS],
                      {FPG_PAGE_BITS{1'b0}}};
              st  <= FPG_ERASE;
            end else begin
              ptr   <= user_go ? xw_addr_in : dbg_in.addr;
              wbyte <= user_go ? xw_data_in : dbg_in.wdata;
              st    <= FPG_WRITE;
            end
          end
        end
        FPG_ERASE: begin
          ptr <= ptr + 1'b1;
          if (page_end) st <= FPG_IDLE;
        end
        FPG_FULL: begin
          ptr <= ptr + 1'b1;
          if (&ptr) begin
            lock_val <= FPG_ERASED;
            st       <= FPG_IDLE;
          end
        end
        FPG_WRITE: st <= FPG_IDLE;
        default:   st <= FPG_IDLE;
      endcase
    end
  end

  wire busy_next = !rst_in && (st == FPG_BOOT || dbg_full ||
    user_go || dbg_go ||
    (st == FPG_ERASE && !page_end) || (st == FPG_FULL && !(&ptr)));

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sfr_rdata_out   <= 8'h00;
      crd_data_out    <= 8'h00;
      crd_seen        <= 1'b0;
      stall_out       <= 1'b1;
      irq_hold_out    <= 1'b1;
      dbg_busy_out    <= 1'b1;
      reset_req_out   <= 1'b0;
      xw_to_flash_out <= 1'b0;
    end else begin
      sfr_rdata_out   <= next_sfr_rdata;
      crd_seen        <= crd_in && st == FPG_IDLE;
      crd_data_out    <= crd_seen ? rdata : 8'h00;
      stall_out       <= busy_next;
      irq_hold_out    <= busy_next;
      dbg_busy_out    <= busy_next;
      reset_req_out   <= user_bad;
      xw_to_flash_out <= psc[FPG_WE_BIT];
    end
  end
endmodule
